// ---- rtl/edpc_event_count.sv ----
// event counters with idle timer that clears them after a quiet period
module edpc_event_count #(
    parameter int IDLE_CYCLES = edpc_pkg::IDLE_CLEAR_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // events and results
    edpc_evt_if.counter evt
);
    import edpc_pkg::*;

    logic [3:0] data_cnt, next_data_cnt;
    logic [3:0] err_cnt, next_err_cnt;
    logic [31:0] idle, next_idle;
    logic expire;

    assign expire = (idle == 32'(IDLE_CYCLES - 1));
    assign evt.data_reach = (data_cnt >= evt.data_thr);
    assign evt.err_reach = (err_cnt >= evt.err_thr);

    always_comb begin
        next_data_cnt = data_cnt;
        next_err_cnt = err_cnt;
        next_idle = idle;
        if (evt.clr || expire) begin
            next_data_cnt = 4'h0;
            next_err_cnt = 4'h0;
            next_idle = 32'h0;
        end else begin
            if (evt.data_evt) begin
                next_idle = 32'h0;
                if (data_cnt != 4'hf) begin
                    next_data_cnt = data_cnt + 4'h1;
                end
            end else begin
                next_idle = idle + 32'h1;
            end
            if (evt.err_evt && err_cnt != 4'hf) begin
                next_err_cnt = err_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_cnt <= 4'h0;
            err_cnt <= 4'h0;
            idle <= 32'h0;
        end else begin
            data_cnt <= next_data_cnt;
            err_cnt <= next_err_cnt;
            idle <= next_idle;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_data_count_step: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (evt.data_evt && !evt.clr && !expire && data_cnt != 4'hf) |=> data_cnt == $past(data_cnt) + 4'h1)
        else $error("data event not counted");

    chk_idle_clear: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        expire |=> (data_cnt == 4'h0 && err_cnt == 4'h0 && idle == 32'h0))
        else $error("counters not cleared after idle time");

endmodule : edpc_event_count

// ---- rtl/edpc_evt_if.sv ----
// interface: event strobes, thresholds and threshold results between control and counters
interface edpc_evt_if;
    logic data_evt;
    logic err_evt;
    logic clr;
    logic [3:0] data_thr;
    logic [3:0] err_thr;
    logic data_reach;
    logic err_reach;

    modport counter (
        input data_evt, err_evt, clr, data_thr, err_thr,
        output data_reach, err_reach
    );
    modport ctrl (
        output data_evt, err_evt, clr, data_thr, err_thr,
        input data_reach, err_reach
    );
endinterface : edpc_evt_if

// ---- rtl/edpc_pkg.sv ----
// package: register map, field positions, reset values and timing for energy-detect power control
package edpc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] CTRL_IDX = 8'h1d;
    localparam logic [7:0] STAT_IDX = 8'h1e;
    localparam logic [7:0] ICLR_IDX = 8'h1f;
    localparam logic [7:0] IEN_IDX = 8'h20;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int EN_BIT = 15;
    localparam int AUTO_UP_BIT = 14;
    localparam int AUTO_DN_BIT = 13;
    localparam int MANUAL_BIT = 12;
    localparam int BURST_DIS_BIT = 11;
    localparam int PWR_STATE_BIT = 10;
    localparam int ERR_MET_BIT = 9;
    localparam int DATA_MET_BIT = 8;
    localparam int ERR_THR_LSB = 4;
    localparam int DATA_THR_LSB = 0;
    localparam int THR_W = 4;
    localparam logic [15:0] CTRL_RESET = 16'h6011;
    localparam logic [15:0] CTRL_WR_MASK = 16'he8ff;

    // ------------------------------------------------------------
    // interrupt status bits
    // ------------------------------------------------------------
    localparam int ST_DATA_MET = 0;
    localparam int ST_ERR_MET = 1;
    localparam int ST_PWR_CHG = 2;
    localparam int ST_W = 3;
    localparam logic [ST_W-1:0] ST_RESET = 3'h0;

    // ------------------------------------------------------------
    // pulses and timing
    // ------------------------------------------------------------
    localparam logic [2:0] BURST_PULSES = 3'h4;
    localparam logic [2:0] SINGLE_PULSE = 3'h1;
    localparam logic [3:0] PULSE_SPACING = 4'h8;
    localparam int CLK_HZ = 250000000;
    localparam int IDLE_CLEAR_S = 2;
    localparam int IDLE_CLEAR_CYCLES = IDLE_CLEAR_S * CLK_HZ;

    typedef enum logic [1:0] {
        PWR_DOWN,
        PWR_BURST,
        PWR_UP
    } edpc_state_t;

    // merge write data into a register under byte enables
    function automatic logic [31:0] edpc_apply_be(input logic [31:0] old_v, input logic [31:0] wdata,
                                                  input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [7:0] edpc_byte_addr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction

endpackage : edpc_pkg

// ---- rtl/edpc_top.sv ----
// top: energy-detect power control with avalon-mm register slave and interrupt
// Behaviour
// - Power management acts only while the enable bit 15 is set (a burst already begun still runs on to PWR_UP), and that bit resets to zero.
// - With auto power-up bit 14 set (reset one), power-up starts once data events reach the data threshold.
// - With auto power-down bit 13 set (reset one), power-down starts once the line shows no energy.
// - Writing one to bit 12 toggles the power state regardless of thresholds and timers, and the bit self-clears.
// - Every power-up emits a burst of 4 detect pulses, or one pulse when burst-disable bit 11 is set.
// - Read-only bit 10 shows one in PWR_UP or PWR_BURST and zero in PWR_DOWN, even with the mode off and the transceiver powered.
// - Bit 9 sets when the error threshold is met, causes no action, and clears on a read of the register.
// - Bit 8 sets when data events equal or exceed the data threshold and clears on a read of the register.
// - Bits 7:4 hold the error threshold, reset 0001, compared against the error event count.
// - Bits 3:0 hold the data threshold, reset 0001, compared against the data event count.
// - Event counters clear after about 2 seconds with no data events, timed from the system clock.
module edpc_top #(
    parameter int IDLE_CYCLES = edpc_pkg::IDLE_CLEAR_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // avalon-mm slave
    input wire logic [edpc_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [edpc_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [edpc_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // detector side
    input wire logic data_evt_i,
    input wire logic err_evt_i,
    input wire logic line_energy_i,
    // transceiver side
    output logic xcvr_power_up_o,
    output logic detect_pulse_o,
    // interrupt
    output logic irq_o
);
    import edpc_pkg::*;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic req, take;
    logic sel_ctrl, sel_stat, sel_iclr, sel_ien;
    logic wr_ctrl, rd_ctrl_taken, wr_iclr, wr_ien;

    assign req = avs_read_i | avs_write_i;
    assign take = req & ack;
    // one wait cycle lets read data come from a flop
    assign avs_waitrequest_o = req & ~ack;
    assign avs_readdata_o = rdata;

    assign sel_ctrl = (avs_address_i == edpc_byte_addr(CTRL_IDX));
    assign sel_stat = (avs_address_i == edpc_byte_addr(STAT_IDX));
    assign sel_iclr = (avs_address_i == edpc_byte_addr(ICLR_IDX));
    assign sel_ien = (avs_address_i == edpc_byte_addr(IEN_IDX));
    assign wr_ctrl = take & avs_write_i & sel_ctrl;
    assign rd_ctrl_taken = take & avs_read_i & sel_ctrl;
    assign wr_iclr = take & avs_write_i & sel_iclr;
    assign wr_ien = take & avs_write_i & sel_ien;

    // ------------------------------------------------------------
    // control and flags
    // ------------------------------------------------------------
    logic [15:0] ctrl, next_ctrl;
    logic data_met, next_data_met;
    logic err_met, next_err_met;
    logic data_reach_q, err_reach_q;
    logic data_rise, err_rise;
    logic [ST_W-1:0] stat, next_stat;
    logic [ST_W-1:0] ien, next_ien;
    logic [ST_W-1:0] st_evt;
    logic irq;
    logic en, auto_up, auto_dn, burst_dis;
    logic manual_go;
    logic pwr_up;
    logic [31:0] ctrl_merged;
    logic [31:0] iclr_merged;
    logic [31:0] ien_merged;
    logic [15:0] ctrl_view;

    assign en = ctrl[EN_BIT];
    assign auto_up = ctrl[AUTO_UP_BIT];
    assign auto_dn = ctrl[AUTO_DN_BIT];
    assign burst_dis = ctrl[BURST_DIS_BIT];
    assign ctrl_merged = edpc_apply_be({16'h0, ctrl}, avs_writedata_i, avs_byteenable_i);
    assign iclr_merged = edpc_apply_be(32'h0, avs_writedata_i, avs_byteenable_i);
    assign ien_merged = edpc_apply_be({29'h0, ien}, avs_writedata_i, avs_byteenable_i);
    // manual request is a pulse, never stored, so the bit reads back as zero
    assign manual_go = wr_ctrl & avs_byteenable_i[1] & avs_writedata_i[MANUAL_BIT] & en;

    edpc_evt_if evt ();

    // flags set on the cycle a threshold is first met, so a later read can clear them
    assign data_rise = evt.data_reach & ~data_reach_q;
    assign err_rise = evt.err_reach & ~err_reach_q;

    always_comb begin
        ctrl_view = ctrl & CTRL_WR_MASK;
        ctrl_view[PWR_STATE_BIT] = pwr_up;
        ctrl_view[ERR_MET_BIT] = err_met;
        ctrl_view[DATA_MET_BIT] = data_met;
    end

    always_comb begin
        next_ack = req & ~ack;
        next_rdata = rdata;
        if (req && !ack) begin
            next_rdata = 32'h0;
            if (avs_read_i) begin
                if (sel_ctrl) begin
                    next_rdata = {16'h0, ctrl_view};
                end else if (sel_stat) begin
                    next_rdata = {29'h0, stat};
                end else if (sel_ien) begin
                    next_rdata = {29'h0, ien};
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack <= 1'b0;
            rdata <= 32'h0;
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl = ctrl_merged[15:0] & CTRL_WR_MASK;
        end
        // set wins over clear-on-read
        next_data_met = data_rise | (data_met & ~rd_ctrl_taken);
        next_err_met = err_rise | (err_met & ~rd_ctrl_taken);
        st_evt = '0;
        st_evt[ST_DATA_MET] = data_rise;
        st_evt[ST_ERR_MET] = err_rise;
        st_evt[ST_PWR_CHG] = 1'b0;
        next_stat = stat;
        if (wr_iclr) begin
            next_stat = stat & ~iclr_merged[ST_W-1:0];
        end
        next_ien = ien;
        if (wr_ien) begin
            next_ien = ien_merged[ST_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    edpc_state_t state, next_state;
    logic [2:0] pcnt, next_pcnt;
    logic [3:0] gap, next_gap;
    logic pulse, next_pulse;
    logic xpwr, next_xpwr;
    logic start_up, start_dn;
    logic pwr_chg;

    assign pwr_up = (state != PWR_DOWN);
    assign start_up = en & (manual_go | (auto_up & evt.data_reach));
    assign start_dn = en & (manual_go | (auto_dn & ~line_energy_i));

    always_comb begin
        next_state = state;
        next_pcnt = pcnt;
        next_gap = gap;
        next_pulse = 1'b0;
        case (state)
            PWR_DOWN: begin
                if (start_up) begin
                    next_state = PWR_BURST;
                    next_pcnt = burst_dis ? SINGLE_PULSE : BURST_PULSES;
                    next_gap = 4'h0;
                end
            end
            PWR_BURST: begin
                if (en && manual_go) begin
                    next_state = PWR_DOWN;
                end else if (gap == 4'h0) begin
                    next_pulse = 1'b1;
                    next_pcnt = pcnt - 3'h1;
                    next_gap = PULSE_SPACING - 4'h1;
                    if (pcnt == 3'h1) begin
                        next_state = PWR_UP;
                    end
                end else begin
                    next_gap = gap - 4'h1;
                end
            end
            PWR_UP: begin
                if (start_dn) begin
                    next_state = PWR_DOWN;
                end
            end
            default: begin
                next_state = PWR_DOWN;
            end
        endcase
        // the transceiver stays powered while the mode is off
        next_xpwr = ~en | (next_state != PWR_DOWN);
    end

    assign pwr_chg = (pwr_up != (next_state != PWR_DOWN));

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= PWR_DOWN;
            pcnt <= 3'h0;
            gap <= 4'h0;
            pulse <= 1'b0;
            xpwr <= 1'b1;
        end else begin
            state <= next_state;
            pcnt <= next_pcnt;
            gap <= next_gap;
            pulse <= next_pulse;
            xpwr <= next_xpwr;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl <= CTRL_RESET;
            data_met <= 1'b0;
            err_met <= 1'b0;
            stat <= ST_RESET;
            ien <= ST_RESET;
            irq <= 1'b0;
            data_reach_q <= 1'b0;
            err_reach_q <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            data_met <= next_data_met;
            err_met <= next_err_met;
            // new events win over a clear in the same cycle
            stat <= next_stat | st_evt | {pwr_chg, 2'b00};
            ien <= next_ien;
            irq <= |((next_stat | st_evt | {pwr_chg, 2'b00}) & next_ien);
            data_reach_q <= evt.data_reach;
            err_reach_q <= evt.err_reach;
        end
    end

    // ------------------------------------------------------------
    // counters and outputs
    // ------------------------------------------------------------
    // events count only while the mode runs; error events never drive the state machine
    assign evt.data_evt = data_evt_i & en;
    assign evt.err_evt = err_evt_i & en;
    assign evt.clr = (state == PWR_DOWN) & start_up;
    assign evt.data_thr = ctrl[DATA_THR_LSB +: THR_W];
    assign evt.err_thr = ctrl[ERR_THR_LSB +: THR_W];

    edpc_event_count #(
        .IDLE_CYCLES(IDLE_CYCLES)
    ) u_count (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .evt(evt.counter)
    );

    assign xcvr_power_up_o = xpwr;
    assign detect_pulse_o = pulse;
    assign irq_o = irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_mode_off_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (!en && state != PWR_BURST) |=> (state == $past(state) && xcvr_power_up_o))
        else $error("power state moved while mode disabled");

    chk_auto_up_start: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state == PWR_DOWN && en && auto_up && evt.data_reach) |=> state == PWR_BURST)
        else $error("auto power-up did not start");

    chk_auto_down_start: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state == PWR_UP && en && auto_dn && !line_energy_i) |=> (state == PWR_DOWN && !xcvr_power_up_o))
        else $error("auto power-down did not start");

    chk_manual_toggle: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (manual_go && state == PWR_UP) |=> (state == PWR_DOWN && ctrl[MANUAL_BIT] == 1'b0))
        else $error("manual toggle failed");

    chk_burst_load: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state == PWR_DOWN && next_state == PWR_BURST)
        |=> pcnt == ($past(burst_dis) ? SINGLE_PULSE : BURST_PULSES))
        else $error("wrong pulse count loaded for burst");

    chk_burst_pulse: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state == PWR_BURST && gap == 4'h0 && !manual_go) |=> detect_pulse_o)
        else $error("detect pulse missing in burst");

    chk_pwr_state_read: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        rd_ctrl_taken |-> avs_readdata_o[PWR_STATE_BIT] == $past(pwr_up))
        else $error("power state bit does not match state");

    chk_err_met_clear: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (rd_ctrl_taken && !err_rise) |=> !err_met)
        else $error("error flag not cleared on read");

    chk_data_met_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        data_rise |=> data_met)
        else $error("data flag not set at threshold");

    chk_thr_drive: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_ctrl && avs_byteenable_i[0] |=> evt.err_thr == $past(avs_writedata_i[7:4]))
        else $error("error threshold not taken from write");

    chk_wait_one: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (req && !ack) |=> (!avs_waitrequest_o || !req))
        else $error("waitrequest held more than one cycle");

    chk_data_thr_drive: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_ctrl && avs_byteenable_i[0] |=> evt.data_thr == $past(avs_writedata_i[3:0]))
        else $error("data threshold not taken from write");

    chk_data_met_clear: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (rd_ctrl_taken && !data_rise) |=> !data_met)
        else $error("data flag not cleared on read");

    chk_pulse_in_burst: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        detect_pulse_o |-> $past(state) == PWR_BURST)
        else $error("detect pulse outside a burst");

    chk_burst_exit: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state == PWR_BURST && gap == 4'h0 && pcnt == 3'h1 && !manual_go) |=> state == PWR_UP)
        else $error("burst did not end after its last pulse");

    chk_down_unpowered: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (en && state == PWR_DOWN && !start_up) |=> !xcvr_power_up_o)
        else $error("transceiver powered while mode is down");

    chk_irq_level: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        irq_o == (|(stat & ien)))
        else $error("interrupt level does not follow enabled status");

endmodule : edpc_top

// ---- verif/edpc_line_model.sv ----
// line receiver model: detector strobes and line energy level
module edpc_line_model (
    // clock
    input wire logic sys_clk_i,
    // detector outputs
    output logic data_evt_o,
    output logic err_evt_o,
    output logic line_energy_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        data_evt_o = 1'b0;
        err_evt_o = 1'b0;
        line_energy_o = 1'b0;
    end

    // ------------------------------------------------------------
    // stimulus tasks
    // ------------------------------------------------------------
    // a quiet cycle between strobes, as a sliced detector would give
    task automatic strobe(input bit is_err, input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            err_evt_o <= is_err;
            data_evt_o <= !is_err;
            @(posedge sys_clk_i);
            err_evt_o <= 1'b0;
            data_evt_o <= 1'b0;
        end
    endtask

    task automatic energy(input bit on);
        @(posedge sys_clk_i);
        line_energy_o <= on;
    endtask
endmodule // edpc_line_model

// ---- verif/energy_detect_power_control_test.sv ----
// testbench: registers, power sequencing, pulses, flags and interrupt of the energy-detect block
module energy_detect_power_control_test;
    import edpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} edpc_row_t;

    logic sys_clk;
    logic arst_n;
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic waitreq;
    logic data_evt;
    logic err_evt;
    logic energy;
    logic pwr;
    logic pulse;
    logic irq;
    int err_count = 0;
    int num_checks = 0;
    // zero thresholds are met at once; manual bit ignored while disabled; read-only and write-only places
    edpc_row_t rows[7] = '{'{8'h74, 32'h0, 32'h0300}, '{8'h74, 32'h7fff, 32'h68ff}, '{8'h74, 32'h0823, 32'h0823},
        '{8'h80, 32'h7, 32'h7}, '{8'h80, 32'h0, 32'h0}, '{8'h7c, 32'h7, 32'h0}, '{8'h40, 32'hffff, 32'h0}};

    // ------------------------------------------------------------
    // design and line model
    // ------------------------------------------------------------
    edpc_top #(.IDLE_CYCLES(64)) edpc_top_i (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .avs_address_i(address),
        .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .data_evt_i(data_evt), .err_evt_i(err_evt),
        .line_energy_i(energy), .xcvr_power_up_o(pwr), .detect_pulse_o(pulse), .irq_o(irq));

    edpc_line_model edpc_line_model_i (.sys_clk_i(sys_clk), .data_evt_o(data_evt), .err_evt_o(err_evt),
        .line_energy_o(energy));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge sys_clk);
        address <= a;
        wdata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitreq !== 1'b0);
        check("wait cycles", 32'd2, n);
        q = rdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic pulses(input int exp);
        int c = 0;
        repeat (40) begin
            @(posedge sys_clk);
            if (pulse === 1'b1) c++;
        end
        check("pulse count", exp, c);
    endtask

    task automatic wait_pwr(input logic exp);
        int n = 0;
        while (pwr !== exp && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        check("power", exp, pwr);
    endtask

    task automatic test_done();
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // whole sequence is a few hundred cycles; this leaves ample margin
    initial begin
        #200000;
        err_count++;
        test_done();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        arst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 8'h0;
        wdata = 32'h0;
        repeat (6) @(posedge sys_clk);
        check("power in reset", 1'b1, pwr);
        arst_n <= 1'b1;
        bus(1'b0, 8'h74, 32'h0, q);
        check("ctrl reset", 32'h6011, q);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].w, q);
            bus(1'b0, rows[i].a, 32'h0, q);
            check("register", rows[i].r, q);
        end
        // auto power-up at threshold 3 with full burst
        // no crossover or negotiation logic here, so enabling needs no other write
        bus(1'b1, 8'h74, 32'he013, q);
        wait_pwr(1'b0);
        bus(1'b1, 8'h7c, 32'h7, q);
        edpc_line_model_i.energy(1'b1);
        edpc_line_model_i.strobe(1'b0, 2);
        repeat (4) @(posedge sys_clk);
        check("power below threshold", 1'b0, pwr);
        edpc_line_model_i.strobe(1'b0, 1);
        pulses(4);
        check("power auto up", 1'b1, pwr);
        bus(1'b0, 8'h74, 32'h0, q);
        check("state and data flag", 3'b101, q[10:8]);
        bus(1'b0, 8'h74, 32'h0, q);
        check("data flag after read", 1'b0, q[8]);
        bus(1'b0, 8'h78, 32'h0, q);
        check("status", 32'h5, q);
        check("irq masked", 1'b0, irq);
        bus(1'b1, 8'h80, 32'h4, q);
        repeat (2) @(posedge sys_clk);
        check("irq enabled", 1'b1, irq);
        bus(1'b1, 8'h7c, 32'h4, q);
        repeat (2) @(posedge sys_clk);
        check("irq cleared", 1'b0, irq);
        edpc_line_model_i.energy(1'b0);
        wait_pwr(1'b0);
        // manual toggle up with single pulse, then down
        // burst disable goes in first: the toggle acts on the setting that already stands
        bus(1'b1, 8'h74, 32'h8811, q);
        bus(1'b1, 8'h74, 32'h9811, q);
        pulses(1);
        check("power manual up", 1'b1, pwr);
        bus(1'b0, 8'h74, 32'h0, q);
        check("manual bit and state", 2'b01, {q[12], q[10]});
        bus(1'b1, 8'h74, 32'h9011, q);
        wait_pwr(1'b0);
        // error threshold 2, informational only
        bus(1'b1, 8'h74, 32'h8021, q);
        edpc_line_model_i.strobe(1'b1, 1);
        bus(1'b0, 8'h74, 32'h0, q);
        check("error flag early", 1'b0, q[9]);
        edpc_line_model_i.strobe(1'b1, 1);
        bus(1'b0, 8'h74, 32'h0, q);
        check("error flag", 1'b1, q[9]);
        check("no action on errors", 1'b0, pwr);
        bus(1'b0, 8'h74, 32'h0, q);
        check("error flag after read", 1'b0, q[9]);
        bus(1'b1, 8'h74, 32'h0021, q);
        wait_pwr(1'b1);
        // quiet period clears the count before the threshold is reached
        edpc_line_model_i.energy(1'b1);
        bus(1'b1, 8'h74, 32'he012, q);
        wait_pwr(1'b0);
        edpc_line_model_i.strobe(1'b0, 1);
        repeat (100) @(posedge sys_clk);
        edpc_line_model_i.strobe(1'b0, 1);
        repeat (4) @(posedge sys_clk);
        check("count cleared by idle", 1'b0, pwr);
        edpc_line_model_i.strobe(1'b0, 1);
        wait_pwr(1'b1);
        // mid-run reset: outputs and registers return to their reset values
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("irq after reset", 1'b0, irq);
        check("pulse after reset", 1'b0, pulse);
        arst_n <= 1'b1;
        bus(1'b0, 8'h74, 32'h0, q);
        check("ctrl after reset", 32'h6011, q);
        test_done();
    end
endmodule // energy_detect_power_control_test
